// >>> design/aeqv_pkg.sv
// formats, addresses, reset values and helpers for the equalizer and volume path
//
// Operation
// - 24-bit 1.23 input samples are sign extended to 3.23, two headroom bits.
// - accumulator results outside 3.23 range saturate when taken out.
// - biquad coefficients a1 a2 b0 b1 b2 are signed 2.20 values.
// - biquad output sums b terms on inputs plus a terms on outputs.
// - filter products use 48-bit double precision arithmetic, biquad sums 51 bits.
// - both stereo channels pass a common seven section equalizer cascade.
// - two crossover sections per main channel, three on the mono sum.
// - first order high-pass on input, one 2.20 coefficient at location 180.
// - high-pass coefficient resets to a 2.75 Hz corner at 44.1 kHz.
// - output clipper before modulators passes magnitudes up to 1/0.75.
// - separate ramped volume register for left, right and sub.
// - volume word is 2.20 signed gain and resets to 1.0.
// - fast ramp takes 1024 frames from 2.0 to zero.
// - slow ramp takes 8192 frames from 2.0 to zero.
// - mute ramps to zero, unmute ramps back to the held volume.
// - volume gain is applied after all filter sections.
// - each of the three outputs has its own delay compensation.
// - processed sub may be added back into left and right outputs.
package aeqv_pkg;
  localparam int IN_W = 24;
  localparam int SMP_W = 26;
  localparam int COEF_W = 22;
  localparam int ACC_W = 48;
  localparam int COEF_FRAC = 20;
  localparam int NUM_EQ = 7;
  localparam int NUM_XMAIN = 2;
  localparam int NUM_XSUB = 3;
  localparam int NUM_STEPS = 2 * NUM_EQ + 2 * NUM_XMAIN + NUM_XSUB;
  localparam int NUM_SETS = NUM_EQ + NUM_XMAIN + NUM_XSUB;
  localparam int COEF_PER_SET = 5;
  localparam int NUM_COEFS = NUM_SETS * COEF_PER_SET;
  localparam int STEP_W = 5;
  localparam int CADDR_W = 6;
  localparam int NUM_CH = 3;

  // section order within a frame
  localparam logic [STEP_W-1:0] STEP_EQR = 5'h07;
  localparam logic [STEP_W-1:0] STEP_XL = 5'h0e;
  localparam logic [STEP_W-1:0] STEP_XR = 5'h10;
  localparam logic [STEP_W-1:0] STEP_SUB = 5'h12;
  localparam logic [STEP_W-1:0] STEP_LAST = 5'h14;

  // coefficient slot within a set
  localparam logic [CADDR_W-1:0] K_B0 = 6'h00;
  localparam logic [CADDR_W-1:0] K_B1 = 6'h01;
  localparam logic [CADDR_W-1:0] K_B2 = 6'h02;
  localparam logic [CADDR_W-1:0] K_A1 = 6'h03;
  localparam logic [CADDR_W-1:0] K_A2 = 6'h04;

  // parameter write addresses
  localparam logic [7:0] ADDR_HPF = 8'hb4;
  localparam logic [7:0] ADDR_VOL = 8'hc8;
  localparam logic [7:0] ADDR_DLY = 8'hcb;

  // 2.20 values; high-pass default = 1-exp(-2*pi*2.75/44100) scaled by 2^20
  localparam logic [COEF_W-1:0] COEF_ONE = 22'h100000;
  localparam logic [COEF_W-1:0] HPF_DEFAULT = 22'h00019b;
  localparam logic [COEF_W-1:0] VOL_RESET = COEF_ONE;

  // ramp: span of 2.0 in 2.20 covered in the frame counts
  localparam int VOL_SPAN = 2097152;
  localparam int RAMP_FAST_FRAMES = 1024;
  localparam int RAMP_SLOW_FRAMES = 8192;
  localparam int VOL_STEP_FAST = VOL_SPAN / RAMP_FAST_FRAMES;
  localparam int VOL_STEP_SLOW = VOL_SPAN / RAMP_SLOW_FRAMES;

  // 3.23 limits and the dac clip level, floor(2^23/0.75)
  localparam logic [SMP_W-1:0] SMP_MAX = 26'h1ffffff;
  localparam logic [SMP_W-1:0] SMP_MIN = 26'h2000000;
  localparam logic [SMP_W-1:0] CLIP_MAX = 26'h0aaaaaa;
  localparam logic [SMP_W-1:0] CLIP_MIN = 26'h3555556;

  typedef logic signed [SMP_W-1:0] aeqv_smp_t;
  typedef logic signed [COEF_W-1:0] aeqv_coef_t;

  // saturate a value at 3.23 scale to the sample range
  function automatic logic [SMP_W-1:0] sat_sample(input logic signed [63:0] v);
    if (v > 64'sh0000_0000_01ff_ffff) return SMP_MAX;
    if (v < 64'shffff_ffff_fe00_0000) return SMP_MIN;
    return v[SMP_W-1:0];
  endfunction

  // limit a sample to the modulator input range
  function automatic logic [SMP_W-1:0] clip_dac(input logic signed [SMP_W-1:0] s);
    if (s > $signed(CLIP_MAX)) return CLIP_MAX;
    if (s < $signed(CLIP_MIN)) return CLIP_MIN;
    return s;
  endfunction
endpackage

// >>> design/aeqv_vol_if.sv
// carrier between the core and one volume ramp
`timescale 1ns/1ps
interface aeqv_vol_if;
  logic frameTick;
  logic slowRamp;
  logic mute;
  logic wrEn;
  logic [aeqv_pkg::COEF_W-1:0] wrData;
  logic signed [aeqv_pkg::COEF_W-1:0] gain;
  modport core (output frameTick, slowRamp, mute, wrEn, wrData, input gain);
  modport ramp (input frameTick, slowRamp, mute, wrEn, wrData, output gain);
endinterface

// >>> design/aeqv_biquad.sv
// one second-order section, combinational, double precision sum
`timescale 1ns/1ps
module aeqv_biquad (
  // input history
  input wire aeqv_pkg::aeqv_smp_t x,
  input wire aeqv_pkg::aeqv_smp_t x1,
  input wire aeqv_pkg::aeqv_smp_t x2,
  // output history
  input wire aeqv_pkg::aeqv_smp_t y1,
  input wire aeqv_pkg::aeqv_smp_t y2,
  // coefficients
  input wire aeqv_pkg::aeqv_coef_t b0,
  input wire aeqv_pkg::aeqv_coef_t b1,
  input wire aeqv_pkg::aeqv_coef_t b2,
  input wire aeqv_pkg::aeqv_coef_t a1,
  input wire aeqv_pkg::aeqv_coef_t a2,
  // result
  output aeqv_pkg::aeqv_smp_t y
);
  localparam int SUM_W = aeqv_pkg::ACC_W + 3;
  logic signed [aeqv_pkg::ACC_W-1:0] pB0, pB1, pB2, pA1, pA2;
  logic signed [SUM_W-1:0] acc;

  assign pB0 = x * b0;
  assign pB1 = x1 * b1;
  assign pB2 = x2 * b2;
  assign pA1 = y1 * a1;
  assign pA2 = y2 * a2;
  // feedback terms are added, not subtracted
  assign acc = SUM_W'(pB0) + SUM_W'(pB1) + SUM_W'(pB2) + SUM_W'(pA1) + SUM_W'(pA2);
  assign y = aeqv_pkg::sat_sample(64'(acc >>> aeqv_pkg::COEF_FRAC));
endmodule // aeqv_biquad

// >>> design/aeqv_vol_ramp.sv
// clickless volume register with per-frame ramp
`timescale 1ns/1ps
module aeqv_vol_ramp (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // control and gain
  aeqv_vol_if.ramp vol
);
  localparam logic signed [aeqv_pkg::COEF_W:0] STEP_F = 23'(aeqv_pkg::VOL_STEP_FAST);
  localparam logic signed [aeqv_pkg::COEF_W:0] STEP_S = 23'(aeqv_pkg::VOL_STEP_SLOW);

  aeqv_pkg::aeqv_coef_t target;
  aeqv_pkg::aeqv_coef_t gain;
  aeqv_pkg::aeqv_coef_t aim;
  aeqv_pkg::aeqv_coef_t next_gain;
  logic signed [aeqv_pkg::COEF_W:0] gainExt, aimExt, step, up, down;

  // mute aims at zero but leaves the target alone
  assign aim = vol.mute ? '0 : target;
  assign gainExt = 23'(gain);
  assign aimExt = 23'(aim);
  assign step = vol.slowRamp ? STEP_S : STEP_F;
  assign up = gainExt + step;
  assign down = gainExt - step;
  assign next_gain = (gainExt < aimExt) ? ((up > aimExt) ? aim : up[aeqv_pkg::COEF_W-1:0]) :
                     (gainExt > aimExt) ? ((down < aimExt) ? aim : down[aeqv_pkg::COEF_W-1:0]) :
                     gain;
  assign vol.gain = gain;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      target <= aeqv_pkg::VOL_RESET;
      gain <= aeqv_pkg::VOL_RESET;
    end else begin
      if (vol.wrEn) target <= vol.wrData;
      if (vol.frameTick) gain <= next_gain;
    end
  end

  vol_reset_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n) $rose(rst_n) |-> gain == aeqv_pkg::VOL_RESET)
    else $error("volume gain not 1.0 after reset");
  fast_step_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    vol.frameTick && !vol.slowRamp && (gainExt > aimExt + STEP_F)
    |=> gainExt == $past(gainExt) - STEP_F)
    else $error("fast ramp step wrong");
  slow_step_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    vol.frameTick && vol.slowRamp && (gainExt + STEP_S < aimExt)
    |=> gainExt == $past(gainExt) + STEP_S)
    else $error("slow ramp step wrong");
  mute_hold_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    vol.mute && vol.frameTick && gain == '0 |=> gain == '0)
    else $error("muted gain left zero");
  tick_only_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n) !vol.frameTick |=> $stable(gain))
    else $error("gain moved without a frame tick");
endmodule // aeqv_vol_ramp

// >>> design/aeqv_core.sv
// audio path: high-pass, equalizer, crossovers, delay, volume, clip
`timescale 1ns/1ps
module aeqv_core #(
  parameter int DELAY_MAX = 165
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // samples from the serial input port
  input wire logic frameIn,
  input wire logic [aeqv_pkg::IN_W-1:0] inLeft,
  input wire logic [aeqv_pkg::IN_W-1:0] inRight,
  output logic busy,
  // parameter memory writes
  input wire logic paramWe,
  input wire logic [7:0] paramAddr,
  input wire logic [aeqv_pkg::COEF_W-1:0] paramData,
  // control
  input wire logic muteReq,
  input wire logic shutdown,
  input wire logic slowRamp,
  input wire logic subToMains,
  // samples to the modulators
  output logic dacValid,
  output logic [aeqv_pkg::SMP_W-1:0] dacLeft,
  output logic [aeqv_pkg::SMP_W-1:0] dacRight,
  output logic [aeqv_pkg::SMP_W-1:0] dacSub
);
  localparam int DEPTH = DELAY_MAX + 1;
  localparam int PTR_W = $clog2(DEPTH);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DELAY_MAX);
  localparam logic [PTR_W-1:0] PTR_DEPTH = PTR_W'(DEPTH);
  localparam int NS = aeqv_pkg::NUM_STEPS;
  localparam int ACC_W = aeqv_pkg::ACC_W;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_HPF = 2'b01,
    S_RUN = 2'b11,
    S_OUT = 2'b10
  } aeqv_state_e;

  // ******************************
  // helpers
  // ******************************
  // coefficient set used by each step
  function automatic logic [3:0] set_of(input logic [aeqv_pkg::STEP_W-1:0] s);
    if (s < aeqv_pkg::STEP_EQR) return 4'(s);
    if (s < aeqv_pkg::STEP_XL) return 4'(s - aeqv_pkg::STEP_EQR);
    if (s < aeqv_pkg::STEP_XR) return 4'(s - aeqv_pkg::STEP_XL + 5'h07);
    if (s < aeqv_pkg::STEP_SUB) return 4'(s - aeqv_pkg::STEP_XR + 5'h07);
    return 4'(s - aeqv_pkg::STEP_SUB + 5'h09);
  endfunction

  // dc tracker, held with 20 extra fraction bits
  function automatic logic signed [ACC_W-1:0] lp_next(input logic signed [ACC_W-1:0] lp,
      input aeqv_pkg::aeqv_smp_t x, input aeqv_pkg::aeqv_coef_t a);
    logic signed [ACC_W:0] diff;
    logic signed [ACC_W+aeqv_pkg::COEF_W:0] prod;
    diff = (ACC_W+1)'($signed({x, 20'h00000})) - (ACC_W+1)'(lp);
    prod = diff * a;
    return lp + ACC_W'(prod >>> aeqv_pkg::COEF_FRAC);
  endfunction

  function automatic aeqv_pkg::aeqv_smp_t hp_out(input aeqv_pkg::aeqv_smp_t x,
      input logic signed [ACC_W-1:0] lp);
    return aeqv_pkg::sat_sample(64'(x) - 64'(lp >>> aeqv_pkg::COEF_FRAC));
  endfunction

  // ******************************
  // state
  // ******************************
  aeqv_state_e state;
  logic [aeqv_pkg::STEP_W-1:0] step;
  aeqv_pkg::aeqv_smp_t inL, inR, hpL, hpR, prev, eqL, eqR, xoL, xoR, subOut;
  logic signed [ACC_W-1:0] lpL, lpR;
  aeqv_pkg::aeqv_coef_t hpCoef;
  aeqv_pkg::aeqv_coef_t coefMem [aeqv_pkg::NUM_COEFS];
  aeqv_pkg::aeqv_smp_t x1m [NS];
  aeqv_pkg::aeqv_smp_t x2m [NS];
  aeqv_pkg::aeqv_smp_t y1m [NS];
  aeqv_pkg::aeqv_smp_t y2m [NS];
  aeqv_pkg::aeqv_smp_t dlyMem [aeqv_pkg::NUM_CH][DEPTH];
  logic [PTR_W-1:0] dlyVal [aeqv_pkg::NUM_CH];
  logic [PTR_W-1:0] wrPtr;
  logic [2:0] muteSync;
  logic muteLvl;

  wire logic takeFrame;
  wire logic wrCoef;
  wire logic wrHpf;
  wire logic [aeqv_pkg::CADDR_W-1:0] coefBase;
  aeqv_pkg::aeqv_smp_t secIn, secOut, mono, mixL, mixR;
  aeqv_pkg::aeqv_smp_t pre [aeqv_pkg::NUM_CH];
  aeqv_pkg::aeqv_smp_t dlyd [aeqv_pkg::NUM_CH];
  aeqv_pkg::aeqv_smp_t vold [aeqv_pkg::NUM_CH];

  // ******************************
  // decode
  // ******************************
  assign takeFrame = frameIn && (state == S_IDLE);
  assign busy = (state != S_IDLE);
  assign wrCoef = paramWe && (paramAddr < 8'(aeqv_pkg::NUM_COEFS));
  assign wrHpf = paramWe && (paramAddr == aeqv_pkg::ADDR_HPF);
  assign coefBase = 6'(set_of(step)) * 6'(aeqv_pkg::COEF_PER_SET);
  assign mono = aeqv_pkg::sat_sample(64'(eqL) + 64'(eqR));
  assign secIn = (step == '0) ? hpL :
                 (step == aeqv_pkg::STEP_EQR) ? hpR :
                 (step == aeqv_pkg::STEP_XL) ? eqL :
                 (step == aeqv_pkg::STEP_XR) ? eqR :
                 (step == aeqv_pkg::STEP_SUB) ? mono : prev;

  aeqv_biquad uSection (
    .x(secIn),
    .x1(x1m[step]),
    .x2(x2m[step]),
    .y1(y1m[step]),
    .y2(y2m[step]),
    .b0(coefMem[coefBase + aeqv_pkg::K_B0]),
    .b1(coefMem[coefBase + aeqv_pkg::K_B1]),
    .b2(coefMem[coefBase + aeqv_pkg::K_B2]),
    .a1(coefMem[coefBase + aeqv_pkg::K_A1]),
    .a2(coefMem[coefBase + aeqv_pkg::K_A2]),
    .y(secOut)
  );

  // ******************************
  // mute pin synchroniser
  // ******************************
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      muteSync <= '0;
      muteLvl <= 1'b0;
    end else begin
      muteSync <= {muteSync[1:0], muteReq};
      if (muteSync[1] == muteSync[2]) muteLvl <= muteSync[2];
    end
  end

  // ******************************
  // parameter memory
  // ******************************
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      hpCoef <= aeqv_pkg::HPF_DEFAULT;
      for (int i = 0; i < aeqv_pkg::NUM_COEFS; i++) begin
        coefMem[i] <= (i % aeqv_pkg::COEF_PER_SET == 0) ? aeqv_pkg::COEF_ONE : '0;
      end
      for (int c = 0; c < aeqv_pkg::NUM_CH; c++) begin
        dlyVal[c] <= '0;
      end
    end else if (paramWe) begin
      if (wrCoef) coefMem[paramAddr[aeqv_pkg::CADDR_W-1:0]] <= paramData;
      if (wrHpf) hpCoef <= paramData;
      for (int c = 0; c < aeqv_pkg::NUM_CH; c++) begin
        if (paramAddr == aeqv_pkg::ADDR_DLY + 8'(c)) begin
          dlyVal[c] <= (paramData > 22'(DELAY_MAX)) ? PTR_LAST : paramData[PTR_W-1:0];
        end
      end
    end
  end

  // ******************************
  // frame sequencer
  // ******************************
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state <= S_IDLE;
      step <= '0;
    end else begin
      case (state)
        S_IDLE: begin
          step <= '0;
          if (takeFrame) state <= S_HPF;
        end
        S_HPF: state <= S_RUN;
        S_RUN: begin
          if (step == aeqv_pkg::STEP_LAST) state <= S_OUT;
          else step <= step + 5'h01;
        end
        S_OUT: state <= S_IDLE;
        default: state <= S_IDLE;
      endcase
    end
  end

  // ******************************
  // input capture and high-pass
  // ******************************
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      inL <= '0;
      inR <= '0;
      hpL <= '0;
      hpR <= '0;
      lpL <= '0;
      lpR <= '0;
    end else if (takeFrame) begin
      inL <= {{2{inLeft[aeqv_pkg::IN_W-1]}}, inLeft};
      inR <= {{2{inRight[aeqv_pkg::IN_W-1]}}, inRight};
    end else if (state == S_HPF) begin
      hpL <= hp_out(inL, lpL);
      hpR <= hp_out(inR, lpR);
      lpL <= lp_next(lpL, inL, hpCoef);
      lpR <= lp_next(lpR, inR, hpCoef);
    end
  end

  // ******************************
  // section history and taps
  // ******************************
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      for (int i = 0; i < NS; i++) begin
        x1m[i] <= '0;
        x2m[i] <= '0;
        y1m[i] <= '0;
        y2m[i] <= '0;
      end
    end else if (state == S_RUN) begin
      x1m[step] <= secIn;
      x2m[step] <= x1m[step];
      y1m[step] <= secOut;
      y2m[step] <= y1m[step];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      prev <= '0;
      eqL <= '0;
      eqR <= '0;
      xoL <= '0;
      xoR <= '0;
      subOut <= '0;
    end else if (state == S_RUN) begin
      prev <= secOut;
      if (step == aeqv_pkg::STEP_EQR - 5'h01) eqL <= secOut;
      if (step == aeqv_pkg::STEP_XL - 5'h01) eqR <= secOut;
      if (step == aeqv_pkg::STEP_XR - 5'h01) xoL <= secOut;
      if (step == aeqv_pkg::STEP_SUB - 5'h01) xoR <= secOut;
      if (step == aeqv_pkg::STEP_LAST) subOut <= secOut;
    end
  end

  // ******************************
  // per channel delay and volume
  // ******************************
  assign pre[0] = xoL;
  assign pre[1] = xoR;
  assign pre[2] = subOut;

  for (genvar ch = 0; ch < aeqv_pkg::NUM_CH; ch++) begin : g_ch
    aeqv_vol_if volBus();
    logic [PTR_W-1:0] rdIdx;
    logic signed [ACC_W-1:0] prod;

    aeqv_vol_ramp uRamp (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .vol(volBus.ramp)
    );

    assign volBus.frameTick = (state == S_OUT);
    assign volBus.slowRamp = slowRamp;
    assign volBus.mute = muteLvl || shutdown;
    assign volBus.wrEn = paramWe && (paramAddr == aeqv_pkg::ADDR_VOL + 8'(ch));
    assign volBus.wrData = paramData;
    assign rdIdx = (wrPtr >= dlyVal[ch]) ? wrPtr - dlyVal[ch] : wrPtr + PTR_DEPTH - dlyVal[ch];
    assign dlyd[ch] = (dlyVal[ch] == '0) ? pre[ch] : dlyMem[ch][rdIdx];
    // gain after all sections
    assign prod = dlyd[ch] * volBus.gain;
    assign vold[ch] = aeqv_pkg::sat_sample(64'(prod >>> aeqv_pkg::COEF_FRAC));
  end

  assign mixL = subToMains ? aeqv_pkg::sat_sample(64'(vold[0]) + 64'(vold[2])) : vold[0];
  assign mixR = subToMains ? aeqv_pkg::sat_sample(64'(vold[1]) + 64'(vold[2])) : vold[1];

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wrPtr <= '0;
      for (int c = 0; c < aeqv_pkg::NUM_CH; c++) begin
        for (int i = 0; i < DEPTH; i++) begin
          dlyMem[c][i] <= '0;
        end
      end
    end else if (state == S_OUT) begin
      for (int c = 0; c < aeqv_pkg::NUM_CH; c++) begin
        dlyMem[c][wrPtr] <= pre[c];
      end
      wrPtr <= (wrPtr == PTR_LAST) ? '0 : wrPtr + 1'b1;
    end
  end

  // ******************************
  // output clipper
  // ******************************
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      dacValid <= 1'b0;
      dacLeft <= '0;
      dacRight <= '0;
      dacSub <= '0;
    end else begin
      dacValid <= (state == S_OUT);
      if (state == S_OUT) begin
        dacLeft <= aeqv_pkg::clip_dac(mixL);
        dacRight <= aeqv_pkg::clip_dac(mixR);
        dacSub <= aeqv_pkg::clip_dac(vold[2]);
      end
    end
  end

  // ******************************
  // checks
  // ******************************
  frame_latency_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n) takeFrame |-> ##24 dacValid)
    else $error("frame result not out after 24 cycles");
  input_extend_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    takeFrame |=> inL == {{2{$past(inLeft[23])}}, $past(inLeft)})
    else $error("input not sign extended");
  clip_bound_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    dacValid |-> $signed(dacLeft) <= $signed(aeqv_pkg::CLIP_MAX)
      && $signed(dacLeft) >= $signed(aeqv_pkg::CLIP_MIN)
      && $signed(dacSub) <= $signed(aeqv_pkg::CLIP_MAX))
    else $error("dac sample beyond clip level");
  hpf_default_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n) $rose(rst_n) |-> hpCoef == aeqv_pkg::HPF_DEFAULT)
    else $error("high-pass coefficient not at default");
  hpf_write_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n) wrHpf |=> hpCoef == $past(paramData))
    else $error("high-pass coefficient write lost");
  clip_right_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    dacValid |-> $signed(dacRight) <= $signed(aeqv_pkg::CLIP_MAX)
      && $signed(dacRight) >= $signed(aeqv_pkg::CLIP_MIN)
      && $signed(dacSub) >= $signed(aeqv_pkg::CLIP_MIN))
    else $error("right or sub sample beyond clip level");
  sub_mono_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    state == S_RUN && step == aeqv_pkg::STEP_SUB |-> secIn == mono)
    else $error("sub crossover not fed by mono sum");
endmodule // aeqv_core

// >>> verif/aeqv_far_end.sv
// far-end model: modulator sample capture and frame latency count
`timescale 1ns/1ps
module aeqv_far_end (
  // clock
  input wire logic clk_sys,
  // frame handshake at the core
  input wire logic frameIn,
  input wire logic busy,
  // modulator inputs
  input wire logic dacValid,
  input wire logic [aeqv_pkg::SMP_W-1:0] dacLeft,
  input wire logic [aeqv_pkg::SMP_W-1:0] dacRight,
  input wire logic [aeqv_pkg::SMP_W-1:0] dacSub,
  // captured samples
  output logic [aeqv_pkg::SMP_W-1:0] capLeft,
  output logic [aeqv_pkg::SMP_W-1:0] capRight,
  output logic [aeqv_pkg::SMP_W-1:0] capSub,
  output int lat,
  output int nOut
);
  int cnt;
  initial begin
    cnt = 0;
    lat = 0;
    nOut = 0;
  end
  // modulators take a sample only on the valid pulse
  always @(posedge clk_sys) begin
    cnt <= (frameIn && !busy) ? 1 : cnt + 1;
    if (dacValid === 1'b1) begin
      capLeft <= dacLeft;
      capRight <= dacRight;
      capSub <= dacSub;
      lat <= cnt;
      nOut <= nOut + 1;
    end
  end
endmodule // aeqv_far_end

// >>> verif/audio_eq_volume_path_tb.sv
// self-checking bench for the audio path
`timescale 1ns/1ps
module audio_eq_volume_path_tb;
  localparam logic [25:0] HALF = 26'h0400000;
  logic clk_sys = 1'b0, rst_n = 1'b0, frameIn = 1'b0, paramWe = 1'b0;
  logic muteReq = 1'b0, shutdown = 1'b0, slowRamp = 1'b0, subToMains = 1'b0;
  logic [23:0] inLeft = 24'h0, inRight = 24'h0;
  logic [7:0] paramAddr = 8'h0;
  logic [21:0] paramData = 22'h0;
  logic busy, dacValid;
  logic [25:0] dacLeft, dacRight, dacSub, capLeft, capRight, capSub;
  int lat, nOut, n;
  int n_mismatch = 0;
  int num_checks = 0;
  always #5 clk_sys = ~clk_sys;
  aeqv_core #(.DELAY_MAX(7)) dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .frameIn(frameIn),
    .inLeft(inLeft), .inRight(inRight), .busy(busy), .paramWe(paramWe),
    .paramAddr(paramAddr), .paramData(paramData), .muteReq(muteReq), .shutdown(shutdown),
    .slowRamp(slowRamp), .subToMains(subToMains), .dacValid(dacValid),
    .dacLeft(dacLeft), .dacRight(dacRight), .dacSub(dacSub));
  aeqv_far_end far_u (.clk_sys(clk_sys), .frameIn(frameIn), .busy(busy),
    .dacValid(dacValid), .dacLeft(dacLeft), .dacRight(dacRight), .dacSub(dacSub),
    .capLeft(capLeft), .capRight(capRight), .capSub(capSub), .lat(lat), .nOut(nOut));
  // ****************
  // shared tasks
  // ****************
  task automatic chk(input logic [25:0] got, input logic [25:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: sample %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkn(input int got, input int exp);
    num_checks++;
    if (got != exp) begin
      n_mismatch++;
      $display("wrong value at %0t: count %0d expected %0d", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [21:0] d);
    @(posedge clk_sys);
    paramWe <= 1'b1;
    paramAddr <= a;
    paramData <= d;
    @(posedge clk_sys);
    paramWe <= 1'b0;
  endtask
  task automatic send(input logic [23:0] l, input logic [23:0] r);
    int k;
    k = nOut;
    @(posedge clk_sys);
    frameIn <= 1'b1;
    inLeft <= l;
    inRight <= r;
    @(posedge clk_sys);
    frameIn <= 1'b0;
    for (int i = 0; i < 40 && nOut == k; i++) @(posedge clk_sys);
    chkn(nOut, k + 1);
    chkn(lat, 24);
  endtask
  task automatic frames_to(input logic [25:0] tgt, output int cnt);
    cnt = 0;
    do begin
      send(24'h400000, 24'h400000);
      cnt++;
    end while (capLeft !== tgt && cnt < 9000);
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic t_pass;
    wr(aeqv_pkg::ADDR_HPF, 22'h0);
    send(24'h400000, 24'h400000);
    chk(capLeft, HALF);
    chk(capSub, 26'h0800000);
    send(24'h800000, 24'h800000);
    chk(capRight, 26'h3800000);
    chk(capSub, aeqv_pkg::CLIP_MIN);
    send(24'h7fffff, 24'h7fffff);
    chk(capSub, aeqv_pkg::CLIP_MAX);
  endtask
  task automatic t_coef;
    wr(8'h00, 22'h200000);
    send(24'h200000, 24'h0);
    chk(capLeft, 26'h3c00000);
    wr(8'h01, aeqv_pkg::COEF_ONE);
    send(24'h0, 24'h0);
    chk(capLeft, 26'h0200000);
    wr(8'h01, 22'h0);
    for (int s = 0; s < 3; s++) wr(8'(s * 5), 22'h200000);
    send(24'h800000, 24'h800000);
    chk(capLeft, aeqv_pkg::CLIP_MAX);
    for (int s = 0; s < 3; s++) wr(8'(s * 5), aeqv_pkg::COEF_ONE);
  endtask
  task automatic t_delay_sub;
    wr(aeqv_pkg::ADDR_DLY, 22'h1);
    send(24'h200000, 24'h200000);
    send(24'h0, 24'h0);
    chk(capLeft, 26'h0200000);
    chk(capRight, 26'h0);
    wr(aeqv_pkg::ADDR_DLY, 22'h0);
    subToMains <= 1'b1;
    send(24'h200000, 24'h200000);
    chk(capRight, 26'h0600000);
    subToMains <= 1'b0;
  endtask
  task automatic t_ramp;
    wr(aeqv_pkg::ADDR_VOL, 22'h0);
    frames_to(26'h0, n);
    chkn(n, 513);
    chk(capRight, HALF);
    slowRamp <= 1'b1;
    wr(aeqv_pkg::ADDR_VOL, aeqv_pkg::COEF_ONE);
    send(24'h400000, 24'h400000);
    send(24'h400000, 24'h400000);
    chk(capLeft, 26'h0000400);
    slowRamp <= 1'b0;
    frames_to(HALF, n);
    chkn(n, 513);
  endtask
  task automatic t_mute;
    muteReq <= 1'b1;
    frames_to(26'h0, n);
    chkn(n, 513);
    shutdown <= 1'b1;
    muteReq <= 1'b0;
    wr(8'h2d, 22'h080000);
    send(24'h400000, 24'h400000);
    chk(capLeft, 26'h0);
    shutdown <= 1'b0;
    frames_to(HALF, n);
    chkn(n, 513);
    chk(capSub, HALF);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    #1000000;
    n_mismatch++;
    end_of_test();
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    chk({dacLeft[23:0], busy, dacValid}, 26'h0);
    rst_n <= 1'b1;
    t_pass();
    t_coef();
    t_delay_sub();
    t_ramp();
    t_mute();
    end_of_test();
  end
endmodule // audio_eq_volume_path_tb
